// File: core/ilpc_consts.svh
/*
  Constants of the interrupt and low-power control block: register offsets,
  field positions, reset values, vector addresses and timing counts.
  Assumes inclusion by its bare name from the design modules.
*/
`ifndef ILPC_CONSTS_SVH
`define ILPC_CONSTS_SVH

// ============================================================
// register map (byte addresses on the APB side)
`define ILPC_OPT_OFS        12'h0C8
`define ILPC_STAT_OFS       12'h0CC
`define ILPC_OPT_RESET      8'h00
`define ILPC_OPT_WR_MASK    8'h70
`define ILPC_LES_BIT        6
`define ILPC_ESB_BIT        5
`define ILPC_GEN_BIT        4

// ============================================================
// status register field positions
`define ILPC_STAT_CTX_LSB   0
`define ILPC_STAT_ST_LSB    3
`define ILPC_STAT_PEND_LSB  8
`define ILPC_STAT_FRZ_BIT   13

// ============================================================
// vector addresses
`define ILPC_VEC_RESET      12'hFFE
`define ILPC_VEC_NMI        12'hFFC
`define ILPC_VEC_PORTA      12'hFF6
`define ILPC_VEC_PORTB      12'hFF4
`define ILPC_VEC_TIMER      12'hFF2
`define ILPC_VEC_EOC        12'hFF0

// ============================================================
// timing counts
`define ILPC_CPU_DIV        13
`define ILPC_RESP_MIN       6
`define ILPC_RESP_MAX       11
`define ILPC_OSC_SHORT      2048
`define ILPC_OSC_LONG       32768

`endif

// File: core/ilpc_pkg.sv
/*
  Types of the interrupt and low-power control block.
  Assumes the constants header sits beside it in core/.
*/
package ilpc_pkg;
  // ============================================================
  // sequencer states and core contexts, one-hot
  typedef enum logic [4:0] {
    ILPC_ST_RUN  = 5'h01,
    ILPC_ST_RESP = 5'h02,
    ILPC_ST_WAIT = 5'h04,
    ILPC_ST_STOP = 5'h08,
    ILPC_ST_OSC  = 5'h10
  } ilpc_state_t;

  typedef enum logic [2:0] {
    ILPC_CTX_MAIN = 3'h1,
    ILPC_CTX_INT  = 3'h2,
    ILPC_CTX_NMI  = 3'h4
  } ilpc_ctx_t;
endpackage

// File: core/ilpc_cpu_cycle_div.sv
/*
  CPU cycle divider: one-cycle tick every thirteen clock periods while run is high.
  Assumes run is low whenever the oscillator is stopped.
*/
`timescale 1ns/1ps
`include "ilpc_consts.svh"

module ilpc_cpu_cycle_div
  import ilpc_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run,
  output logic      cpu_tick
);
  logic [3:0] cnt_ff;
  logic       tick_ff;

  // ============================================================
  // divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff  <= 4'h0;
      tick_ff <= 1'b0;
    end else if (!run) begin
      cnt_ff  <= 4'h0;
      tick_ff <= 1'b0;
    end else if (cnt_ff == 4'(`ILPC_CPU_DIV - 1)) begin
      cnt_ff  <= 4'h0;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff  <= cnt_ff + 4'h1;
      tick_ff <= 1'b0;
    end
  end

  assign cpu_tick = tick_ff;

  // ============================================================
  // checks
  property p_cpu_period;
    @(posedge pclk) disable iff (!presetn)
      (tick_ff && run) ##1 run[*8] ##1 run[*4] |=> tick_ff;
  endproperty
  a_cpu_period: assert property (p_cpu_period) else $error("cpu tick period is not 13");

  property p_cpu_gap;
    @(posedge pclk) disable iff (!presetn)
      tick_ff |=> (!tick_ff)[*8];
  endproperty
  a_cpu_gap: assert property (p_cpu_gap) else $error("cpu ticks too close");
endmodule

// File: core/ilpc_top.sv
/*
  Interrupt and low-power control: option register on APB, request latches,
  fixed-priority vectoring with response delay, WAIT/STOP sequencing and restart.
  Assumes all pins and core strobes are synchronous to pclk; the core pulses
  wait_exec, stop_exec and reti_exec for one cycle per executed instruction.
*/
// Local design decision: the APB register port.
// Notes on behaviour
// - routine starts 6 to 11 cpu cycles after the vector is loaded.
// - one cpu cycle is thirteen oscillator clock periods.
// - option register is write-only, resets to zero, written as whole byte.
// - level select bit: vector one falling edge when 0, low level when 1.
// - edge select bit: vector two falling edge when 0, rising when 1.
// - global enable gates maskable requests; non-maskable service is never gated.
// - with enable cleared, non-maskable is serviced but never wakes the device.
// - fixed vector addresses and fixed priority reset, nmi, A, B, timer, conversion.
// - all sources but conversion complete wake from STOP.
// - after reset the device runs from the main oscillator.
// - WAIT halts the core but keeps the oscillator and peripherals running.
// - reset, or any interrupt with enable set, ends WAIT; its routine runs only if it can be served at once.
// - STOP halts the core and stops the oscillator.
// - every interrupt exit from STOP waits 2048 or 32768 clocks for oscillator start-up.
// - with watchdog active STOP acts as WAIT unless option and nmi pin high.
// - sleep from main: run the routine, then continue after the sleep.
// - sleep inside nmi routine: continue after sleep, staying in nmi context.
// - sleep in routine, normal wake: continue routine, pending served after return.
// - sleep in routine, nmi wake: nmi routine first, then routine continues.
// - maskable events are latched while enable is cleared.
// - WAIT and STOP are not executed while an enabled request is pending.
// - edge latch sets on active edge, clears at routine start, holds one more.
`timescale 1ns/1ps
`include "ilpc_consts.svh"

module ilpc_top
  import ilpc_pkg::*;
#(
  parameter int OSC_SHORT_CYC = `ILPC_OSC_SHORT,
  parameter int OSC_LONG_CYC  = `ILPC_OSC_LONG
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        nmi_pin,
  input  wire logic        vec1_pin,
  input  wire logic        vec2_pin,
  input  wire logic        timer_underflow_flag,
  input  wire logic        conversion_done_flag,
  input  wire logic        wdg_active,
  input  wire logic        external_stop_control_option,
  input  wire logic        osc_delay_long,
  input  wire logic [2:0]  instr_left,
  input  wire logic        wait_exec,
  input  wire logic        stop_exec,
  input  wire logic        reti_exec,
  output logic             vec_load,
  output logic [11:0]      vector_addr,
  output logic             isr_start,
  output logic             resume_next,
  output logic             core_halt,
  output logic             osc_run,
  output logic             wdg_freeze,
  output logic [2:0]       context_out
);
  // ============================================================
  // declarations
  ilpc_state_t st_ff;
  ilpc_state_t nxt_st;
  ilpc_ctx_t   ctx_ff;
  ilpc_ctx_t   saved_ctx_ff;
  logic [7:0]  opt_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [2:0]  prev_ff;
  logic [2:0]  latch_ff;
  logic [2:0]  hit;
  logic [2:0]  clr;
  logic [4:0]  pend;
  logic [2:0]  src_ff;
  logic [2:0]  sel_src;
  logic        sel_valid;
  logic        boot_ff;
  logic        vec_load_ff;
  logic [11:0] vector_addr_ff;
  logic        isr_start_ff;
  logic        resume_next_ff;
  logic        core_halt_ff;
  logic        osc_run_ff;
  logic        wdg_freeze_ff;
  logic [3:0]  resp_cnt_ff;
  logic [3:0]  resp_target_ff;
  logic [15:0] osc_cnt_ff;
  logic [15:0] osc_target_ff;
  logic        cpu_tick;
  logic        gen;
  logic        vector_one_level_select;
  logic        vector_two_edge_select;
  logic        mask_any;
  logic        en_pend;
  logic        wake_wait;
  logic        wake_stop;
  logic        osc_done;
  logic        restart;
  logic        take_now;
  logic        serve;
  logic        resume;
  logic        boot_go;
  logic        sleep_req;
  logic        stop_as_wait;
  logic        to_stop;
  logic        to_wait;
  logic        isr_go;
  logic        apb_setup;
  logic        apb_done;
  logic        hit_opt;
  logic        hit_stat;

  function automatic logic [11:0] vec_of(input logic [2:0] src);
    logic [11:0] v;
    v = `ILPC_VEC_EOC;
    unique case (src)
      3'h0:    v = `ILPC_VEC_NMI;
      3'h1:    v = `ILPC_VEC_PORTA;
      3'h2:    v = `ILPC_VEC_PORTB;
      3'h3:    v = `ILPC_VEC_TIMER;
      default: v = `ILPC_VEC_EOC;
    endcase
    return v;
  endfunction

  // ============================================================
  // apb slave, one wait state on every access
  assign apb_setup = psel && penable && !pready_ff;
  assign apb_done  = psel && penable && pready_ff;
  assign hit_opt   = (paddr == `ILPC_OPT_OFS);
  assign hit_stat  = (paddr == `ILPC_STAT_OFS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= apb_setup;
      pslverr_ff <= apb_setup && !hit_opt && !hit_stat;
      prdata_ff  <= 32'h0000_0000;
      if (apb_setup && !pwrite && hit_stat) begin
        prdata_ff[`ILPC_STAT_CTX_LSB +: 3]  <= ctx_ff;
        prdata_ff[`ILPC_STAT_ST_LSB +: 5]   <= st_ff;
        prdata_ff[`ILPC_STAT_PEND_LSB +: 5] <= pend;
        prdata_ff[`ILPC_STAT_FRZ_BIT]       <= wdg_freeze_ff;
      end
    end
  end

  // a byte write lands only with lane 0 strobed; reserved bits are kept at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_ff <= `ILPC_OPT_RESET;
    end else if (apb_done && pwrite && hit_opt && pstrb[0]) begin
      opt_ff <= pwdata[7:0] & `ILPC_OPT_WR_MASK;
    end
  end

  assign gen = opt_ff[`ILPC_GEN_BIT];
  assign vector_one_level_select = opt_ff[`ILPC_LES_BIT];
  assign vector_two_edge_select = opt_ff[`ILPC_ESB_BIT];

  // ============================================================
  // request latches: nmi, vector one, vector two
  always_comb begin
    hit[0] = prev_ff[0] && !nmi_pin;
    hit[1] = !vector_one_level_select && prev_ff[1] && !vec1_pin;
    hit[2] = vector_two_edge_select ? (!prev_ff[2] && vec2_pin) : (prev_ff[2] && !vec2_pin);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_ff <= 3'h7;
    end else begin
      prev_ff <= {vec2_pin, vec1_pin, nmi_pin};
    end
  end

  // set wins over clear, so an edge in the clearing cycle is kept
  for (genvar i = 0; i < 3; i++) begin : g_latch
    assign clr[i] = isr_go && (src_ff == 3'(i));
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        latch_ff[i] <= 1'b0;
      end else begin
        latch_ff[i] <= hit[i] || (latch_ff[i] && !clr[i]);
      end
    end
  end

  // level mode stores nothing: the pin must still be low when sampled
  assign pend = {conversion_done_flag, timer_underflow_flag, latch_ff[2],
                 vector_one_level_select ? !vec1_pin : latch_ff[1], latch_ff[0]};

  // ============================================================
  // priority selection
  always_comb begin
    sel_valid = 1'b0;
    sel_src   = 3'h0;
    if (pend[0] && ctx_ff != ILPC_CTX_NMI) begin
      sel_valid = 1'b1;
    end else if (gen && ctx_ff == ILPC_CTX_MAIN) begin
      for (int k = 4; k >= 1; k--) begin
        if (pend[k]) begin
          sel_valid = 1'b1;
          sel_src   = 3'(k);
        end
      end
    end
  end

  assign mask_any     = |pend[4:1];
  assign en_pend      = pend[0] || (gen && mask_any);
  assign wake_wait    = (st_ff == ILPC_ST_WAIT) && gen && (pend[0] || mask_any);
  assign wake_stop    = (st_ff == ILPC_ST_STOP) && gen && (|pend[3:0]);
  assign osc_done     = (st_ff == ILPC_ST_OSC) && (osc_cnt_ff == osc_target_ff);
  assign restart      = wake_wait || osc_done;
  assign boot_go      = (st_ff == ILPC_ST_RUN) && boot_ff;
  assign take_now     = (st_ff == ILPC_ST_RUN) && !boot_ff && cpu_tick && sel_valid;
  assign serve        = take_now || (restart && sel_valid);
  assign resume       = restart && !sel_valid;
  assign sleep_req    = (st_ff == ILPC_ST_RUN) && !boot_ff && (wait_exec || stop_exec) && !en_pend;
  assign stop_as_wait = wdg_active && !(external_stop_control_option && nmi_pin);
  assign to_stop      = sleep_req && stop_exec && !wait_exec && !stop_as_wait;
  assign to_wait      = sleep_req && !to_stop;
  assign isr_go       = (st_ff == ILPC_ST_RESP) && cpu_tick && (resp_cnt_ff == resp_target_ff - 4'h1);

  // ============================================================
  // sequencer
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      ILPC_ST_RUN: begin
        if (serve) begin
          nxt_st = ILPC_ST_RESP;
        end else if (to_wait) begin
          nxt_st = ILPC_ST_WAIT;
        end else if (to_stop) begin
          nxt_st = ILPC_ST_STOP;
        end
      end
      ILPC_ST_RESP: begin
        if (isr_go) begin
          nxt_st = ILPC_ST_RUN;
        end
      end
      ILPC_ST_WAIT: begin
        if (restart) begin
          nxt_st = serve ? ILPC_ST_RESP : ILPC_ST_RUN;
        end
      end
      ILPC_ST_STOP: begin
        if (wake_stop) begin
          nxt_st = ILPC_ST_OSC;
        end
      end
      ILPC_ST_OSC: begin
        if (osc_done) begin
          nxt_st = serve ? ILPC_ST_RESP : ILPC_ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= ILPC_ST_RUN;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // reset vector is fetched once after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_ff <= 1'b1;
    end else if (boot_go) begin
      boot_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_load_ff    <= 1'b0;
      vector_addr_ff <= `ILPC_VEC_RESET;
      src_ff         <= 3'h0;
      isr_start_ff   <= 1'b0;
      resume_next_ff <= 1'b0;
    end else begin
      vec_load_ff    <= boot_go || serve;
      isr_start_ff   <= isr_go;
      resume_next_ff <= resume;
      if (boot_go) begin
        vector_addr_ff <= `ILPC_VEC_RESET;
      end else if (serve) begin
        vector_addr_ff <= vec_of(sel_src);
        src_ff         <= sel_src;
      end
    end
  end

  // oscillator and watchdog freeze follow the next state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_halt_ff  <= 1'b0;
      osc_run_ff    <= 1'b1;
      wdg_freeze_ff <= 1'b0;
    end else begin
      core_halt_ff <= (nxt_st == ILPC_ST_WAIT) || (nxt_st == ILPC_ST_STOP) || (nxt_st == ILPC_ST_OSC);
      osc_run_ff   <= (nxt_st != ILPC_ST_STOP);
      if (to_stop && wdg_active) begin
        wdg_freeze_ff <= 1'b1;
      end else if (osc_done) begin
        wdg_freeze_ff <= 1'b0;
      end
    end
  end

  // ============================================================
  // context tracking; one level of nmi nesting over a routine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctx_ff       <= ILPC_CTX_MAIN;
      saved_ctx_ff <= ILPC_CTX_MAIN;
    end else if (serve) begin
      if (sel_src == 3'h0) begin
        saved_ctx_ff <= ctx_ff;
        ctx_ff       <= ILPC_CTX_NMI;
      end else begin
        ctx_ff <= ILPC_CTX_INT;
      end
    end else if (reti_exec && st_ff == ILPC_ST_RUN) begin
      ctx_ff <= (ctx_ff == ILPC_CTX_NMI) ? saved_ctx_ff : ILPC_CTX_MAIN;
    end
  end

  // ============================================================
  // response and start-up counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_cnt_ff    <= 4'h0;
      resp_target_ff <= 4'(`ILPC_RESP_MIN);
    end else if (serve) begin
      resp_cnt_ff    <= 4'h0;
      // position inside the current instruction adds up to five cycles
      resp_target_ff <= 4'(`ILPC_RESP_MIN) + ((instr_left > 3'h5) ? 4'h5 : {1'b0, instr_left});
    end else if (st_ff == ILPC_ST_RESP && cpu_tick) begin
      resp_cnt_ff <= resp_cnt_ff + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_cnt_ff    <= 16'h0000;
      osc_target_ff <= 16'h0000;
    end else if (wake_stop) begin
      osc_cnt_ff    <= 16'h0000;
      osc_target_ff <= osc_delay_long ? 16'(OSC_LONG_CYC - 1) : 16'(OSC_SHORT_CYC - 1);
    end else if (st_ff == ILPC_ST_OSC) begin
      osc_cnt_ff <= osc_cnt_ff + 16'h0001;
    end
  end

  // divider stops with the oscillator
  ilpc_cpu_cycle_div u_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .run      (st_ff == ILPC_ST_RUN || st_ff == ILPC_ST_RESP || st_ff == ILPC_ST_WAIT),
    .cpu_tick (cpu_tick)
  );

  assign prdata      = prdata_ff;
  assign pready      = pready_ff;
  assign pslverr     = pslverr_ff;
  assign vec_load    = vec_load_ff;
  assign vector_addr = vector_addr_ff;
  assign isr_start   = isr_start_ff;
  assign resume_next = resume_next_ff;
  assign core_halt   = core_halt_ff;
  assign osc_run     = osc_run_ff;
  assign wdg_freeze  = wdg_freeze_ff;
  assign context_out = ctx_ff;

  // ============================================================
  // checks
  sequence s_vec_int;
    vec_load_ff && vector_addr_ff != `ILPC_VEC_RESET;
  endsequence

  property p_resp_time;
    @(posedge pclk) disable iff (!presetn)
      s_vec_int |-> ##[66:156] isr_start_ff;
  endproperty
  a_resp_time: assert property (p_resp_time) else $error("response time out of range");

  property p_opt_read_zero;
    @(posedge pclk) disable iff (!presetn)
      (apb_done && !pwrite && hit_opt) |-> prdata_ff == 32'h0000_0000;
  endproperty
  a_opt_read_zero: assert property (p_opt_read_zero) else $error("option register read not zero");

  property p_v1_edge;
    @(posedge pclk) disable iff (!presetn)
      (!vector_one_level_select && $fell(vec1_pin)) |=> latch_ff[1];
  endproperty
  a_v1_edge: assert property (p_v1_edge) else $error("vector one falling edge lost");

  property p_v2_rise;
    @(posedge pclk) disable iff (!presetn)
      (vector_two_edge_select && $rose(vec2_pin)) |=> latch_ff[2];
  endproperty
  a_v2_rise: assert property (p_v2_rise) else $error("vector two rising edge lost");

  property p_gen_block;
    @(posedge pclk) disable iff (!presetn)
      (vec_load_ff && !$past(gen)) |-> (vector_addr_ff == `ILPC_VEC_NMI || vector_addr_ff == `ILPC_VEC_RESET);
  endproperty
  a_gen_block: assert property (p_gen_block) else $error("maskable vector with enable cleared");

  property p_no_wake_gen_off;
    @(posedge pclk) disable iff (!presetn)
      (st_ff == ILPC_ST_WAIT && !gen) |=> st_ff == ILPC_ST_WAIT;
  endproperty
  a_no_wake_gen_off: assert property (p_no_wake_gen_off) else $error("woke with enable cleared");

  property p_eoc_no_stop_wake;
    @(posedge pclk) disable iff (!presetn)
      (st_ff == ILPC_ST_STOP && !(|pend[3:0])) |=> st_ff == ILPC_ST_STOP;
  endproperty
  a_eoc_no_stop_wake: assert property (p_eoc_no_stop_wake) else $error("left STOP without wake source");

  sequence s_stop_exit;
    st_ff == ILPC_ST_STOP ##1 st_ff == ILPC_ST_OSC;
  endsequence

  property p_osc_hold;
    @(posedge pclk) disable iff (!presetn)
      s_stop_exit |-> (st_ff == ILPC_ST_OSC && core_halt_ff)[*8];
  endproperty
  a_osc_hold: assert property (p_osc_hold) else $error("start-up delay cut short");

  property p_wdg_wait;
    @(posedge pclk) disable iff (!presetn)
      (sleep_req && stop_exec && stop_as_wait) |=> (st_ff == ILPC_ST_WAIT && osc_run_ff);
  endproperty
  a_wdg_wait: assert property (p_wdg_wait) else $error("STOP not executed as WAIT");

  property p_nmi_ctx_resume;
    @(posedge pclk) disable iff (!presetn)
      (wake_wait && ctx_ff == ILPC_CTX_NMI) |=> (resume_next_ff && ctx_ff == ILPC_CTX_NMI && !vec_load_ff);
  endproperty
  a_nmi_ctx_resume: assert property (p_nmi_ctx_resume) else $error("nmi context resume wrong");

  property p_no_sleep_pending;
    @(posedge pclk) disable iff (!presetn)
      (st_ff == ILPC_ST_RUN && (wait_exec || stop_exec) && en_pend) |=> !core_halt_ff;
  endproperty
  a_no_sleep_pending: assert property (p_no_sleep_pending) else $error("slept with request pending");
endmodule

// File: sim/ilpc_core_model.sv
/*
  Core-side partner: turns bench requests into one-cycle wait, stop and
  return strobes. Assumes requests last one pclk cycle.
*/
`timescale 1ns/1ps
module ilpc_core_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [2:0] req,
  output logic            wait_exec,
  output logic            stop_exec,
  output logic            reti_exec
);
  // ============================================================
  // strobes
  // registered so a request is seen as exactly one executed instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {wait_exec, stop_exec, reti_exec} <= 3'h0;
    end else begin
      {wait_exec, stop_exec, reti_exec} <= req;
    end
  end
endmodule

// File: sim/ilpc_tb.sv
/*
  Self-checking bench for the interrupt and low-power controller.
  Assumes short start-up counts; pins and strobes change after pclk edges.
*/
`timescale 1ns/1ps
module interrupt_and_low_power_control_tb;
  import ilpc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr, vector_addr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        nmi_pin, vec1_pin, vec2_pin, tmr, eoc, wdg, xsc, dl;
  logic        wait_exec, stop_exec, reti_exec, vec_load, isr_start;
  logic        resume_next, core_halt, osc_run, wdg_freeze;
  logic [2:0]  req, context_out, il;
  int          error_cnt, num_checks, n;

  ilpc_top #(.OSC_SHORT_CYC(10), .OSC_LONG_CYC(20)) dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .nmi_pin, .vec1_pin, .vec2_pin,
    .timer_underflow_flag(tmr), .conversion_done_flag(eoc), .wdg_active(wdg),
    .external_stop_control_option(xsc), .osc_delay_long(dl),
    .instr_left(il), .wait_exec, .stop_exec, .reti_exec, .vec_load,
    .vector_addr, .isr_start, .resume_next, .core_halt, .osc_run,
    .wdg_freeze, .context_out
  );
  ilpc_core_model core_u (.pclk, .presetn, .req, .wait_exec, .stop_exec, .reti_exec);

  // ============================================================
  // helpers
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic close_out();
    if (error_cnt == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  // pulse a core strobe, then let model and controller registers settle
  task automatic pulse(input logic [2:0] r);
    req <= r;
    @(posedge pclk);
    req <= 3'h0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic wait_vec(input logic [11:0] a);
    n = 0;
    while (vec_load !== 1'h1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    chk("vec_load", 32'h1, 32'(vec_load));
    chk("vector_addr", 32'(a), 32'(vector_addr));
  endtask

  task automatic to_isr();
    n = 0;
    while (isr_start !== 1'h1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    chk("isr_start", 32'h1, 32'(isr_start));
  endtask

  // ============================================================
  // scenarios
  task automatic t_boot_reg();
    wait_vec(12'hFFE);
    chk("context_out", 32'h1, 32'(context_out));
    chk("osc_run", 32'h1, 32'(osc_run));
    apb(1'h1, 12'h0C8, 32'h10);
    apb(1'h0, 12'h0C8, 32'h0);
    chk("option_read", 32'h0, rd);
    apb(1'h0, 12'h100, 32'h0);
    chk("pslverr", 32'h1, 32'(er));
  endtask

  task automatic t_edge_nmi();
    vec1_pin <= 1'h0;
    wait_vec(12'hFF6);
    chk("context_out", 32'h2, 32'(context_out));
    to_isr();
    chk("isr_in_window", 32'h1, 32'(n >= 76 && n <= 80));
    vec1_pin <= 1'h1;
    nmi_pin <= 1'h0;
    wait_vec(12'hFFC);
    chk("context_out", 32'h4, 32'(context_out));
    to_isr();
    nmi_pin <= 1'h1;
    pulse(3'h1);
    chk("context_out", 32'h2, 32'(context_out));
    pulse(3'h1);
    chk("context_out", 32'h1, 32'(context_out));
  endtask

  task automatic t_wait();
    pulse(3'h4);
    chk("core_halt", 32'h1, 32'(core_halt));
    chk("osc_run", 32'h1, 32'(osc_run));
    tmr <= 1'h1;
    wait_vec(12'hFF2);
    tmr <= 1'h0;
    to_isr();
    pulse(3'h1);
  endtask

  task automatic t_stop();
    pulse(3'h2);
    chk("osc_run", 32'h0, 32'(osc_run));
    eoc <= 1'h1;
    repeat (40) @(posedge pclk);
    chk("osc_run", 32'h0, 32'(osc_run));
    eoc <= 1'h0;
    vec2_pin <= 1'h0;
    repeat (4) @(posedge pclk);
    n = 0;
    while (core_halt === 1'h1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    chk("startup_delay", 32'h1, 32'(n >= 9 && n <= 10));
    wait_vec(12'hFF4);
    vec2_pin <= 1'h1;
    to_isr();
    pulse(3'h1);
    wdg <= 1'h1;
    pulse(3'h2);
    chk("osc_run", 32'h1, 32'(osc_run));
    chk("core_halt", 32'h1, 32'(core_halt));
  endtask

  task automatic t_ctx();
    apb(1'h1, 12'h0C8, 32'h0);
    nmi_pin <= 1'h0;
    repeat (20) @(posedge pclk);
    chk("core_halt", 32'h1, 32'(core_halt));
    nmi_pin <= 1'h1;
    apb(1'h1, 12'h0C8, 32'h30);
    wait_vec(12'hFFC);
    to_isr();
    pulse(3'h4);
    vec2_pin <= 1'h0;
    @(posedge pclk);
    vec2_pin <= 1'h1;
    repeat (3) @(posedge pclk);
    chk("resume_next", 32'h1, 32'(resume_next));
    chk("context_out", 32'h4, 32'(context_out));
    il <= 3'h7;
    pulse(3'h1);
    wait_vec(12'hFF4);
    to_isr();
    chk("isr_late", 32'h1, 32'(n >= 141 && n <= 145));
    il <= 3'h0;
    pulse(3'h1);
  endtask

  task automatic t_freeze();
    apb(1'h1, 12'h0C8, 32'h50);
    xsc <= 1'h1;
    dl <= 1'h1;
    pulse(3'h2);
    chk("osc_run", 32'h0, 32'(osc_run));
    chk("wdg_freeze", 32'h1, 32'(wdg_freeze));
    vec1_pin <= 1'h0;
    wait_vec(12'hFF6);
    chk("wdg_freeze", 32'h0, 32'(wdg_freeze));
    vec1_pin <= 1'h1;
    to_isr();
    pulse(3'h1);
  endtask

  // ============================================================
  // clock, reset, sequence and watchdog
  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end

  initial begin
    {presetn, psel, penable, pwrite, tmr, eoc, wdg, xsc, dl} = 9'h0;
    {nmi_pin, vec1_pin, vec2_pin} = 3'h7;
    {paddr, pwdata, pstrb, req, il} = 54'h0;
    error_cnt = 0;
    num_checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    t_boot_reg();
    t_edge_nmi();
    t_wait();
    t_stop();
    t_ctx();
    t_freeze();
    close_out();
  end

  // generous bound: the scenarios need well under two thousand cycles
  initial begin
    #80000;
    error_cnt++;
    close_out();
  end
endmodule
